// ### src/acs_seq.sv
// A/D conversion sequencer: acquisition, conversion, abort, wait, discharge
`timescale 1ns/1ps
module acs_seq
    import acs_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             adc_enable,
    input  wire logic             go_set,
    input  wire logic             go_clear,
    input  wire logic [2:0]       acquisition_time_select,
    input  wire logic             instr_done,
    input  wire logic             result_wr,
    input  wire logic [acs_pkg::RES_W-1:0] result_wr_data,
    input  wire logic             cmp_in,
    output logic                  go_flag,
    output logic [7:0]            result_high_byte,
    output logic [7:0]            result_low_byte,
    output logic [acs_pkg::RES_W-1:0] sar_code,
    output logic                  sample_en,
    output logic                  discharge_en,
    output logic                  conv_busy
);
    import acs_pkg::*;

    acs_seq_t q;
    acs_seq_t d;
    logic     tick;
    logic     go_next;

    acs_prd_if prd ();

    acs_prd_gen u_prd (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .prd      (prd)
    );

    assign tick        = prd.tick;
    assign prd.restart = (d.st != q.st);
    // Set wins over clear; go ignored while converter is off
    // Abort looks at this, not at d.go, so completion is not taken for an abort
    assign go_next     = (go_set & adc_enable) | (q.go & ~go_clear); // RULE7

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.go = go_next;
        if (result_wr) begin
            d.res = result_wr_data;
        end
        unique case (q.st)
            S_DISCH: begin
                d.discharge = 1'b1;
                d.sample    = 1'b0;
                if (tick) begin
                    if (q.cnt == CNT_ONE) begin
                        d.st        = S_IDLE;
                        d.discharge = 1'b0;
                        d.sample    = 1'b1; // RULE6
                    end else begin
                        d.cnt = q.cnt - CNT_ONE;
                    end
                end
            end
            S_IDLE: begin
                d.sample = 1'b1;
                if (q.go) begin
                    d.busy = 1'b1;
                    if (acquisition_time_select == ACQ_NONE) begin
                        d.st = S_WAIT; // RULE1
                    end else begin
                        d.st  = S_ACQ; // RULE2
                        d.cnt = acq_prds(acquisition_time_select);
                    end
                end
            end
            S_WAIT: begin
                if (instr_done) begin
                    d.st      = S_CONV; // RULE1
                    d.sample  = 1'b0;
                    d.sar     = {1'b1, {(RES_W-1){1'b0}}};
                    d.bit_idx = BIT_MSB;
                end
            end
            S_ACQ: begin
                if (tick) begin
                    if (q.cnt == CNT_ONE) begin
                        d.st      = S_CONV; // RULE2
                        d.sample  = 1'b0;
                        d.sar     = {1'b1, {(RES_W-1){1'b0}}};
                        d.bit_idx = BIT_MSB;
                    end else begin
                        d.cnt = q.cnt - CNT_ONE;
                    end
                end
            end
            S_CONV: begin
                if (tick) begin
                    d.sar[q.bit_idx] = cmp_in;
                    if (q.bit_idx == BIT_LSB) begin
                        d.res  = d.sar; // RULE9
                        d.go   = go_set & adc_enable; // RULE9
                        d.st   = S_HOLD; // RULE5
                        d.cnt  = POST_PRDS;
                        d.busy = 1'b0;
                    end else begin
                        d.sar[q.bit_idx - BIT_STEP] = 1'b1;
                        d.bit_idx = q.bit_idx - BIT_STEP;
                    end
                end
            end
            S_HOLD: begin
                if (tick) begin
                    if (q.cnt == CNT_ONE) begin
                        d.st        = S_DISCH; // RULE8
                        d.cnt       = DISCH_PRDS;
                        d.discharge = 1'b1;
                    end else begin
                        d.cnt = q.cnt - CNT_ONE; // RULE5
                    end
                end
            end
            default: begin
                d.st = S_DISCH;
            end
        endcase
        // Abort keeps the old result pair
        if ((q.st == S_WAIT || q.st == S_ACQ || q.st == S_CONV) && !go_next) begin
            d.st     = S_HOLD; // RULE3
            d.cnt    = POST_PRDS; // RULE5
            d.sample = 1'b0;
            d.busy   = 1'b0;
            d.res    = result_wr ? result_wr_data : q.res; // RULE4
        end
        if (!adc_enable) begin
            d.st        = S_DISCH;
            d.cnt       = DISCH_PRDS;
            d.discharge = 1'b1;
            d.sample    = 1'b0;
            d.busy      = 1'b0;
            d.go        = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= SEQ_RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign go_flag          = q.go;
    assign result_high_byte = {HIGH_PAD, q.res[RES_W-1:8]};
    assign result_low_byte  = q.res[7:0];
    assign sar_code         = q.sar;
    assign sample_en        = q.sample;
    assign discharge_en     = q.discharge;
    assign conv_busy        = q.busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_instr_wait_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
        (q.st == S_WAIT && !instr_done) |=> (q.st != S_CONV))
        else $error("conversion began before the instruction completed");

    a_acq_four_len: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
        (q.st == S_IDLE && q.go && adc_enable && !go_clear
         && acquisition_time_select == ACQ_FOUR)
        |=> (q.st == S_ACQ && q.cnt == 5'h04))
        else $error("acquisition of four periods not loaded");

    a_abort_now: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
        (q.st == S_CONV && go_clear && !go_set && adc_enable)
        |=> (q.st == S_HOLD && !q.busy && !q.go))
        else $error("clearing go did not abort the conversion");

    a_abort_keeps_res: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
        (q.st == S_CONV && go_clear && !go_set && !result_wr) |=> $stable(q.res))
        else $error("result changed on an aborted conversion");

    a_post_wait_len: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        (q.st != S_HOLD ##1 q.st == S_HOLD) |-> (q.cnt == 5'h02))
        else $error("post conversion wait not two periods");

    a_auto_acquire: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
        (q.st == S_DISCH && tick && q.cnt == CNT_ONE && adc_enable)
        |=> (q.st == S_IDLE && q.sample))
        else $error("acquisition did not restart after the wait");

    a_disch_first: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
        $rose(q.sample) |-> $past(q.discharge))
        else $error("sample began without a discharge phase");

    a_done_writes: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
        (q.st == S_CONV && tick && q.bit_idx == BIT_LSB && q.go && !go_clear
         && !go_set && adc_enable)
        |=> (!q.go && q.st == S_HOLD && q.res[0] == $past(cmp_in)))
        else $error("completion did not store result and clear go");

    a_hold_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        (q.st == S_HOLD) |-> (!q.busy && !q.sample && !q.discharge))
        else $error("next acquisition not held off during the wait");

    a_conv_start: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
        (q.st != S_CONV ##1 q.st == S_CONV)
        |-> (!q.sample && q.sar == {1'b1, {(RES_W-1){1'b0}}}))
        else $error("conversion did not begin from the top trial code");

    a_off_discharges: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
        (!adc_enable) |=> (q.st == S_DISCH && q.discharge && !q.go))
        else $error("converter off without discharging the array");

    a_busy_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
        (q.st == S_IDLE || q.st == S_DISCH) |-> !q.busy)
        else $error("busy set outside acquisition or conversion");

endmodule : acs_seq

// ### src/acs_pkg.sv
// Constants, types and state layout of the A/D conversion sequencer
// Function
// (RULE1) Zero acquisition code: conversion starts only after the next instruction completes.
// (RULE2) Acquisition code 010: four conversion clock periods of acquisition before converting.
// (RULE3) Clearing the go flag during a conversion aborts it at once.
// (RULE4) An aborted conversion leaves the result pair untouched.
// (RULE5) Two conversion clock periods of wait after every completion or abort.
// (RULE6) After that wait, acquisition of the selected channel restarts by itself.
// (RULE7) Software must not set go while enabling; wait two microseconds first.
// (RULE8) The capacitor array is discharged before every sample.
// (RULE9) A completed conversion writes the result pair and clears go.
package acs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS     = 40;
    localparam int PRD_NS     = 1000;
    localparam int PRD_CYCLES = (PRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRD_W      = 6;
    localparam logic [PRD_W-1:0] PRD_LAST = PRD_W'(PRD_CYCLES - 1);

    // ----------------------------------------------------------------
    // Widths, codes and counts
    // ----------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int CNT_W = 5;
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] BIT_MSB    = 4'hb;
    localparam logic [BIT_W-1:0] BIT_LSB    = 4'h0;
    localparam logic [BIT_W-1:0] BIT_STEP   = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0] POST_PRDS  = 5'h02;
    localparam logic [CNT_W-1:0] DISCH_PRDS = 5'h01;
    localparam logic [2:0]       ACQ_NONE   = 3'h0;
    localparam logic [2:0]       ACQ_FOUR   = 3'h2;
    localparam logic [RES_W-1:0] RES_ZERO   = 12'h000;
    localparam logic [3:0]       HIGH_PAD   = 4'h0;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_WAIT  = 3'h1,
        S_ACQ   = 3'h2,
        S_CONV  = 3'h3,
        S_HOLD  = 3'h4,
        S_DISCH = 3'h5
    } acs_state_t;

    typedef struct packed {
        acs_state_t       st;
        logic             go;
        logic [CNT_W-1:0] cnt;
        logic [BIT_W-1:0] bit_idx;
        logic [RES_W-1:0] sar;
        logic [RES_W-1:0] res;
        logic             sample;
        logic             discharge;
        logic             busy;
    } acs_seq_t;

    localparam acs_seq_t SEQ_RESET = '{
        st: S_DISCH, go: 1'b0, cnt: DISCH_PRDS, bit_idx: BIT_MSB,
        sar: RES_ZERO, res: RES_ZERO, sample: 1'b0, discharge: 1'b1, busy: 1'b0};

    typedef struct packed {
        logic [PRD_W-1:0] cnt;
        logic             tick;
    } acs_prd_t;

    localparam acs_prd_t PRD_RESET = '{cnt: '0, tick: 1'b0};

    // Acquisition length in conversion clock periods per select code
    function automatic logic [CNT_W-1:0] acq_prds(input logic [2:0] sel);
        logic [CNT_W-1:0] n;
        n = 5'h00;
        unique case (sel)
            3'h0: n = 5'h00;
            3'h1: n = 5'h02;
            3'h2: n = 5'h04;
            3'h3: n = 5'h06;
            3'h4: n = 5'h08;
            3'h5: n = 5'h0c;
            3'h6: n = 5'h10;
            3'h7: n = 5'h14;
        endcase
        return n;
    endfunction : acq_prds

endpackage : acs_pkg

// ### src/acs_tad_if.sv
// Conversion clock tick link between sequencer and tick generator
`timescale 1ns/1ps
interface acs_prd_if;
    logic restart;
    logic tick;
    modport gen  (input restart, output tick);
    modport user (output restart, input tick);
endinterface : acs_prd_if

// ### src/acs_tad_gen.sv
// Conversion clock period tick generator
`timescale 1ns/1ps
module acs_prd_gen
    import acs_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    acs_prd_if.gen    prd
);
    import acs_pkg::*;

    acs_prd_t q;
    acs_prd_t d;

    // ----------------------------------------------------------------
    // Period counter, phase restarts on every sequencer state change
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (prd.restart) begin
            d.cnt = '0;
        end else if (q.cnt == PRD_LAST) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + {{(PRD_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q <= PRD_RESET;
        end else begin
            q <= d;
        end
    end

    assign prd.tick = q.tick;

endmodule : acs_prd_gen

// ### tb/acs_analog_model.sv
// Behavioural sample-and-hold capacitor array with comparator
`timescale 1ns/1ps
module acs_analog_model
    import acs_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic [acs_pkg::RES_W-1:0] analog_level,
    input  wire logic                      sample_en,
    input  wire logic                      discharge_en,
    input  wire logic [acs_pkg::RES_W-1:0] sar_code,
    output logic                           cmp_in
);
    import acs_pkg::*;
    logic [RES_W-1:0] held_q;
    initial held_q = '0;
    // Discharge wipes the array, so a missed sample shows as zero
    always @(posedge core_clk) begin
        if (discharge_en) held_q <= '0;
        else if (sample_en) held_q <= analog_level;
    end
    assign cmp_in = (held_q >= sar_code);
endmodule : acs_analog_model

// ### tb/tb_top.sv
// Self-checking testbench of the A/D conversion sequencer
`timescale 1ns/1ps
module tb_top;
    import acs_pkg::*;
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             adc_enable = 1'b0;
    logic             go_set = 1'b0;
    logic             go_clear = 1'b0;
    logic [2:0]       sel = 3'h0;
    logic             instr_done = 1'b0;
    logic             result_wr = 1'b0;
    logic [RES_W-1:0] wr_data = 12'h000;
    logic [RES_W-1:0] level = 12'h000;
    logic             cmp_in;
    logic             go_flag;
    logic [7:0]       res_hi;
    logic [7:0]       res_lo;
    logic [RES_W-1:0] sar_code;
    logic             sample_en;
    logic             discharge_en;
    logic             conv_busy;
    int               fails = 0;
    int               samples_checked = 0;
    int               n;
    localparam int    WAIT_MAX = 2000;

    always #20 core_clk = ~core_clk;

    acs_seq dut_u (.core_clk(core_clk), .rst_n(rst_n), .adc_enable(adc_enable),
        .go_set(go_set), .go_clear(go_clear), .acquisition_time_select(sel),
        .instr_done(instr_done), .result_wr(result_wr), .result_wr_data(wr_data),
        .cmp_in(cmp_in), .go_flag(go_flag), .result_high_byte(res_hi),
        .result_low_byte(res_lo), .sar_code(sar_code), .sample_en(sample_en),
        .discharge_en(discharge_en), .conv_busy(conv_busy));

    acs_analog_model far_u (.core_clk(core_clk), .analog_level(level),
        .sample_en(sample_en), .discharge_en(discharge_en), .sar_code(sar_code),
        .cmp_in(cmp_in));

    task automatic chk(input string nm, input logic [RES_W-1:0] e, input logic [RES_W-1:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic near(input string nm, input int got, input int e);
        chk(nm, 12'h001, {11'h000, (got >= e - 4 && got <= e + 4)});
    endtask : near

    task automatic chk_res(input logic [RES_W-1:0] e);
        chk("result", e, {res_hi[3:0], res_lo});
        chk("high_pad", 12'h000, {8'h00, res_hi[7:4]});
    endtask : chk_res

    function automatic logic pick(input int k);
        case (k)
            0: return sample_en;
            1: return discharge_en;
            2: return go_flag;
            default: return conv_busy;
        endcase
    endfunction : pick

    // Outputs are looked at on the falling edge, where they have settled
    task automatic wait_lvl(input int k, input logic v, output int cnt);
        cnt = 0;
        @(negedge core_clk);
        while (pick(k) !== v && cnt < WAIT_MAX) begin
            @(negedge core_clk);
            cnt++;
        end
        if (pick(k) !== v) begin
            fails++;
            $display("[ERR] level_wait_%0d expected %b seen %b", k, v, pick(k));
        end
    endtask : wait_lvl

    task automatic pulse_go(input logic [2:0] code);
        @(posedge core_clk);
        sel <= code;
        go_set <= 1'b1;
        @(posedge core_clk);
        go_set <= 1'b0;
    endtask : pulse_go

    // Go taken: flag one edge after the pulse, busy one edge later
    task automatic start_go(input logic [2:0] code);
        pulse_go(code);
        wait_lvl(3, 1'b1, n);
        near("busy_delay", n, 1);
        chk("go_taken", 12'h001, {11'h000, go_flag});
    endtask : start_go

    // Completion or abort: two-period wait, discharge, then sampling again
    task automatic check_tail();
        wait_lvl(1, 1'b1, n);
        near("post_wait", n, 50);
        wait_lvl(0, 1'b1, n);
        near("discharge_len", n, 25);
        chk("auto_acquire", 12'h001, {11'h000, sample_en});
    endtask : check_tail

    task automatic t_reset();
        @(negedge core_clk);
        chk("go_reset", 12'h000, {11'h000, go_flag});
        chk_res(12'h000);
        chk("disch_reset", 12'h001, {11'h000, discharge_en});
        chk("sample_reset", 12'h000, {11'h000, sample_en});
        pulse_go(3'h2);
        @(negedge core_clk);
        chk("go_disabled", 12'h000, {11'h000, go_flag});
        chk("busy_disabled", 12'h000, {11'h000, conv_busy});
        @(posedge core_clk);
        adc_enable <= 1'b1;
        repeat (60) @(posedge core_clk);
        wait_lvl(0, 1'b1, n);
        chk("first_sample", 12'h001, {11'h000, sample_en});
    endtask : t_reset

    task automatic t_acq_four();
        @(posedge core_clk);
        level <= 12'h5a3;
        start_go(3'h2);
        wait_lvl(0, 1'b0, n);
        near("acq_len", n, 100);
        chk("sar_start", 12'h800, sar_code);
        wait_lvl(2, 1'b0, n);
        near("conv_len", n, 300);
        chk_res(12'h5a3);
        chk("sar_final", 12'h5a3, sar_code);
        chk("busy_done", 12'h000, {11'h000, conv_busy});
        check_tail();
    endtask : t_acq_four

    task automatic t_acq_zero();
        @(posedge core_clk);
        level <= 12'h8e1;
        start_go(3'h0);
        repeat (400) @(posedge core_clk);
        @(negedge core_clk);
        chk("go_waiting", 12'h001, {11'h000, go_flag});
        chk("sample_waiting", 12'h001, {11'h000, sample_en});
        chk_res(12'h5a3);
        @(posedge core_clk);
        instr_done <= 1'b1;
        @(posedge core_clk);
        instr_done <= 1'b0;
        wait_lvl(2, 1'b0, n);
        near("conv_len0", n, 300);
        chk_res(12'h8e1);
        check_tail();
    endtask : t_acq_zero

    task automatic t_abort();
        @(posedge core_clk);
        result_wr <= 1'b1;
        wr_data <= 12'h123;
        @(posedge core_clk);
        result_wr <= 1'b0;
        level <= 12'h3c7;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk_res(12'h123);
        start_go(3'h2);
        wait_lvl(0, 1'b0, n);
        repeat (75) @(posedge core_clk);
        go_clear <= 1'b1;
        @(posedge core_clk);
        go_clear <= 1'b0;
        wait_lvl(3, 1'b0, n);
        near("abort_delay", n, 0);
        chk("go_abort", 12'h000, {11'h000, go_flag});
        chk_res(12'h123);
        check_tail();
        chk_res(12'h123);
    endtask : t_abort

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_acq_four();
        t_acq_zero();
        t_abort();
        wrap_up();
    end
endmodule : tb_top
